// ### inc/mifu_map.svh
/*
  register offsets, bit positions, reset values and timing counts of the
  interrupt flag and enable unit.
  assumes a 40 ns system clock and byte-wide registers on 32-bit AXI4-Lite words.
*/
// Contract
// [RL1] pin b edge field bits 3..2: 00 off, 01 rise, 10 fall, 11 both
// [RL2] pin a edge field bits 1..0 uses the same four-way encoding
// [RL3] selected edge on either external pin raises that pin's request flag
// [RL4] edge register bits 7..4 read zero and ignore writes
// [RL5] hardware sets each flag on its source event regardless of enables
// [RL6] software sets individual and global enables to choose interrupting requests
// [RL7] an enabled accepted request suspends the main program for servicing
// [RL8] internal requests come from timers, time bases, detector, eeprom, serials, converter
// [RL9] three group flags each summarise secondary sources with own flag and enable
// [RL10] control 0: group0 flag 6, cmp 5, pin a 4, enables 3..1, global 0
// [RL11] control 1: tb0, converter, group2, group1 flags 7..4, enables 3..0
// [RL12] flags read 1 when pending, are software writable, reset to 0
// [RL13] enable bits block at 0, permit at 1, reset to 0
// [RL14] comparator event sets its flag, gated by its own enable
// [RL15] converter event sets its flag, gated by enable at control 1 bit 2
// [RL16] control 2: async, sync, pin b, tb1 flags 7..4, enables 3..0
// [RL17] group 0: std timer a/p flags 5,4, enables 1,0, bits 3..2 zero
// [RL18] low-voltage flag sets after fixed delay of detector output; wakes from idle
// [RL19] interrupt needs flag, own enable and global enable; grouped needs group enable
// [RL20] group flag sets when any secondary flag and its enable are set
`ifndef MIFU_MAP_SVH
`define MIFU_MAP_SVH

`define MIFU_OFF_EDGE_SEL   8'h00
`define MIFU_OFF_PRI_0      8'h04
`define MIFU_OFF_PRI_1      8'h08
`define MIFU_OFF_PRI_2      8'h0c
`define MIFU_OFF_GRP_0      8'h10
`define MIFU_OFF_GRP_1      8'h14
`define MIFU_OFF_GRP_2      8'h18

`define MIFU_RST_BYTE       8'h00
`define MIFU_WMASK_EDGE     8'h0f
`define MIFU_WMASK_PRI_0    8'h7f
`define MIFU_WMASK_FULL     8'hff
`define MIFU_WMASK_GRP      8'h33

`define MIFU_EDGE_A_LSB     0
`define MIFU_EDGE_B_LSB     2
`define MIFU_FLAG_LSB       4
`define MIFU_P0_GRP0_F      6
`define MIFU_P0_CMP_F       5
`define MIFU_P0_PIN_A_F     4
`define MIFU_P0_GRP0_E      3
`define MIFU_P0_CMP_E       2
`define MIFU_P0_PIN_A_E     1
`define MIFU_P0_GLOBAL_E    0
`define MIFU_P1_TB0_F       7
`define MIFU_P1_ADC_F       6
`define MIFU_P1_GRP2_F      5
`define MIFU_P1_GRP1_F      4
`define MIFU_P2_ASYNC_F     7
`define MIFU_P2_SYNC_F      6
`define MIFU_P2_PIN_B_F     5
`define MIFU_P2_TB1_F       4
`define MIFU_G0_STD_A_F     5
`define MIFU_G0_STD_P_F     4
`define MIFU_G1_CT_A_F      7
`define MIFU_G1_CT_P_F      6
`define MIFU_G1_PT_A_F      5
`define MIFU_G1_PT_P_F      4
`define MIFU_G2_EE_F        5
`define MIFU_G2_LV_F        4
`define MIFU_G2_LV_E        0

`define MIFU_RESP_OKAY      2'h0
`define MIFU_RESP_SLVERR    2'h2

`define MIFU_CLK_PERIOD_NS  40
`define MIFU_LVD_DELAY_NS   1000
`define MIFU_LVD_DELAY_CYC  \
  ((`MIFU_LVD_DELAY_NS + `MIFU_CLK_PERIOD_NS - 1) / `MIFU_CLK_PERIOD_NS)

`endif

// ### inc/mifu_pkg.sv
/*
  types of the interrupt flag and enable unit: edge modes and the bundle of
  peripheral request pulses.
  assumes every event input is a one-cycle pulse synchronous to aclk.
*/
package mifu_pkg;

  typedef enum logic [1:0] {
    MIFU_EDGE_OFF  = 2'h0,
    MIFU_EDGE_RISE = 2'h1,
    MIFU_EDGE_FALL = 2'h2,
    MIFU_EDGE_BOTH = 2'h3
  } mifu_edge_t;

  typedef struct packed {
    logic comparator;
    logic converter;
    logic timebase0;
    logic timebase1;
    logic sync_serial_unit;
    logic async_serial;
    logic eeprom;
    logic std_timer_a_match;
    logic std_timer_p_match;
    logic compact_timer_a_match;
    logic compact_timer_p_match;
    logic periodic_timer_a_match;
    logic periodic_timer_p_match;
  } mifu_src_t;

endpackage : mifu_pkg

// ### hdl/mifu_top.sv
/*
  interrupt request flags, enables, global enable, external pin edge select and
  grouped secondary sources, reached over an AXI4-Lite slave.
  assumes pins and event pulses are synchronous to aclk and the core takes
  irq_req as a level that asks it to suspend the main program.
*/
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`include "mifu_map.svh"

module mifu_top (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                awvalid,
  output      logic                awready,
  input  wire logic [7:0]          awaddr,
  input  wire logic                wvalid,
  output      logic                wready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  output      logic                bvalid,
  input  wire logic                bready,
  output      logic [1:0]          bresp,
  input  wire logic                arvalid,
  output      logic                arready,
  input  wire logic [7:0]          araddr,
  output      logic                rvalid,
  input  wire logic                rready,
  output      logic [31:0]         rdata,
  output      logic [1:0]          rresp,
  input  wire logic                ext_irq_pin_a,
  input  wire logic                ext_irq_pin_b,
  input  wire mifu_pkg::mifu_src_t src_events,
  input  wire logic                low_voltage_output_bit,
  output      logic                irq_req,
  output      logic                lv_wake
);
  import mifu_pkg::*;

  localparam int unsigned NREG   = 7;
  localparam int unsigned IX_EDG = 0;
  localparam int unsigned IX_P0  = 1;
  localparam int unsigned IX_P1  = 2;
  localparam int unsigned IX_P2  = 3;
  localparam int unsigned IX_G0  = 4;
  localparam int unsigned IX_G1  = 5;
  localparam int unsigned IX_G2  = 6;
  localparam logic [7:0]  OFFS [NREG] = '{`MIFU_OFF_EDGE_SEL, `MIFU_OFF_PRI_0,
    `MIFU_OFF_PRI_1, `MIFU_OFF_PRI_2, `MIFU_OFF_GRP_0, `MIFU_OFF_GRP_1, `MIFU_OFF_GRP_2};
  localparam logic [7:0]  WMASK [NREG] = '{`MIFU_WMASK_EDGE, `MIFU_WMASK_PRI_0,
    `MIFU_WMASK_FULL, `MIFU_WMASK_FULL, `MIFU_WMASK_GRP, `MIFU_WMASK_FULL,
    `MIFU_WMASK_GRP};
  localparam logic [7:0]  LV_CYC = 8'(`MIFU_LVD_DELAY_CYC);

  logic [7:0]  regs_q [NREG];
  logic [7:0]  regs_d [NREG];
  logic [7:0]  set_v  [NREG];
  logic [NREG-1:0] wr_hit;
  logic [NREG-1:0] rd_hit;
  logic        aw_hold_q;
  logic        aw_hold_d;
  logic [7:0]  aw_addr_q;
  logic        w_hold_q;
  logic        w_hold_d;
  logic [7:0]  w_byte_q;
  logic        w_lane0_q;
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic        bvalid_d;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic        rvalid_d;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        do_wr;
  logic        ar_take;
  logic [7:0]  rd_byte;
  logic [1:0]  pin_now;
  logic [1:0]  pin_prev_q;
  logic [1:0]  pin_hit;
  logic [7:0]  lv_cnt_q;
  logic        lv_set;
  logic        pend;
  logic        irq_req_q;
  logic        lv_wake_q;

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;
  assign irq_req = irq_req_q;
  assign lv_wake = lv_wake_q;

  // write channel: address and data are caught independently, in either order
  assign do_wr     = aw_hold_q & w_hold_q & ~bvalid_q;
  assign aw_hold_d = do_wr ? 1'b0 : (aw_hold_q | (awvalid & awready_q));
  assign w_hold_d  = do_wr ? 1'b0 : (w_hold_q | (wvalid & wready_q));
  assign bvalid_d  = bvalid_q ? ~bready : do_wr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q  <= w_hold_d;
      awready_q <= ~aw_hold_d & ~bvalid_d;
      wready_q  <= ~w_hold_d & ~bvalid_d;
      bvalid_q  <= bvalid_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= 8'h00;
      w_byte_q  <= 8'h00;
      w_lane0_q <= 1'b0;
      bresp_q   <= `MIFU_RESP_OKAY;
    end else begin
      if (awvalid && awready_q) begin
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready_q) begin
        w_byte_q  <= wdata[7:0];
        w_lane0_q <= wstrb[0];
      end
      if (do_wr) begin
        bresp_q <= (|wr_hit) ? `MIFU_RESP_OKAY : `MIFU_RESP_SLVERR;
      end
    end
  end

  // read channel: one outstanding read, data captured at acceptance
  assign ar_take  = arvalid & arready_q;
  assign rvalid_d = rvalid_q ? ~rready : ar_take;

  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < NREG; i++) begin
      rd_hit[i] = (araddr == OFFS[i]);
      wr_hit[i] = do_wr & (aw_addr_q == OFFS[i]);
      if (rd_hit[i]) begin
        rd_byte = regs_q[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `MIFU_RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_take) begin
        rdata_q <= {24'h00_0000, rd_byte}; // unimplemented bits already held at zero [RL4]
        rresp_q <= (|rd_hit) ? `MIFU_RESP_OKAY : `MIFU_RESP_SLVERR;
      end
    end
  end

  // external pins: edge select per pin
  assign pin_now = {ext_irq_pin_b, ext_irq_pin_a};

  for (genvar g = 0; g < 2; g++) begin : g_pin
    mifu_edge_t sel;
    assign sel = mifu_edge_t'(regs_q[IX_EDG][(g * 2) +: 2]);
    assign pin_hit[g] =
      ((sel == MIFU_EDGE_RISE) & pin_now[g] & ~pin_prev_q[g]) |  // [RL1] [RL2]
      ((sel == MIFU_EDGE_FALL) & ~pin_now[g] & pin_prev_q[g]) |  // [RL1] [RL2]
      ((sel == MIFU_EDGE_BOTH) & (pin_now[g] ^ pin_prev_q[g]));  // [RL1] [RL2]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev_q <= 2'b00;
    end else begin
      pin_prev_q <= pin_now;
    end
  end

  // low-voltage delay: the flag only fires once the output has stayed high
  // for the whole delay, so short dips near the threshold are not reported
  assign lv_set = low_voltage_output_bit & (lv_cnt_q == LV_CYC - 8'h01);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lv_cnt_q <= 8'h00;
    end else if (!low_voltage_output_bit) begin
      lv_cnt_q <= 8'h00;
    end else if (lv_cnt_q != LV_CYC) begin
      lv_cnt_q <= lv_cnt_q + 8'h01; // [RL18]
    end
  end

  // hardware set sources, independent of any enable except the three group flags, which need an enabled secondary
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      set_v[i] = 8'h00;
    end
    set_v[IX_P0][`MIFU_P0_GRP0_F]  = |(regs_q[IX_G0][7:4] & regs_q[IX_G0][3:0]); // [RL20] [RL9]
    set_v[IX_P0][`MIFU_P0_CMP_F]   = src_events.comparator;                     // [RL14] [RL5]
    set_v[IX_P0][`MIFU_P0_PIN_A_F] = pin_hit[0];                                // [RL3]
    set_v[IX_P1][`MIFU_P1_TB0_F]   = src_events.timebase0;                      // [RL8] [RL11]
    set_v[IX_P1][`MIFU_P1_ADC_F]   = src_events.converter;                      // [RL15]
    set_v[IX_P1][`MIFU_P1_GRP2_F]  = |(regs_q[IX_G2][7:4] & regs_q[IX_G2][3:0]); // [RL20]
    set_v[IX_P1][`MIFU_P1_GRP1_F]  = |(regs_q[IX_G1][7:4] & regs_q[IX_G1][3:0]); // [RL20]
    set_v[IX_P2][`MIFU_P2_ASYNC_F] = src_events.async_serial;                   // [RL8] [RL16]
    set_v[IX_P2][`MIFU_P2_SYNC_F]  = src_events.sync_serial_unit;               // [RL8] [RL16]
    set_v[IX_P2][`MIFU_P2_PIN_B_F] = pin_hit[1];                                // [RL3]
    set_v[IX_P2][`MIFU_P2_TB1_F]   = src_events.timebase1;                      // [RL8]
    set_v[IX_G0][`MIFU_G0_STD_A_F] = src_events.std_timer_a_match;              // [RL17]
    set_v[IX_G0][`MIFU_G0_STD_P_F] = src_events.std_timer_p_match;              // [RL17]
    set_v[IX_G1][`MIFU_G1_CT_A_F]  = src_events.compact_timer_a_match;          // [RL8]
    set_v[IX_G1][`MIFU_G1_CT_P_F]  = src_events.compact_timer_p_match;          // [RL8]
    set_v[IX_G1][`MIFU_G1_PT_A_F]  = src_events.periodic_timer_a_match;         // [RL8]
    set_v[IX_G1][`MIFU_G1_PT_P_F]  = src_events.periodic_timer_p_match;         // [RL8]
    set_v[IX_G2][`MIFU_G2_EE_F]    = src_events.eeprom;                         // [RL8]
    set_v[IX_G2][`MIFU_G2_LV_F]    = lv_set;                                    // [RL18]
  end

  // a hardware set in the same cycle as a software clear wins
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      regs_d[i] = regs_q[i];
      if (wr_hit[i] && w_lane0_q) begin
        regs_d[i] = (w_byte_q & WMASK[i]) | (regs_q[i] & ~WMASK[i]); // [RL12] [RL4] [RL10]
      end
      regs_d[i] = regs_d[i] | (set_v[i] & WMASK[i]);                   // [RL5] [RL12]
    end
  end

  always_ff @(posedge aclk) begin
    for (int i = 0; i < NREG; i++) begin
      if (!aresetn) begin
        regs_q[i] <= `MIFU_RST_BYTE; // [RL12] [RL13]
      end else begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  // a group flag is set through enabled secondaries or by a software write, and flag and group
  // enable together stand for the full grouped condition
  always_comb begin
    pend = (regs_q[IX_P0][`MIFU_P0_GRP0_F] & regs_q[IX_P0][`MIFU_P0_GRP0_E])   // [RL19]
         | (regs_q[IX_P0][`MIFU_P0_CMP_F] & regs_q[IX_P0][`MIFU_P0_CMP_E])     // [RL14] [RL13]
         | (regs_q[IX_P0][`MIFU_P0_PIN_A_F] & regs_q[IX_P0][`MIFU_P0_PIN_A_E])
         | (|(regs_q[IX_P1][7:4] & regs_q[IX_P1][3:0]))                         // [RL11] [RL15]
         | (|(regs_q[IX_P2][7:4] & regs_q[IX_P2][3:0]));                        // [RL16]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req_q <= 1'b0;
      lv_wake_q <= 1'b0;
    end else begin
      irq_req_q <= regs_q[IX_P0][`MIFU_P0_GLOBAL_E] & pend; // [RL7] [RL19]
      lv_wake_q <= regs_q[IX_G2][`MIFU_G2_LV_F] & regs_q[IX_G2][`MIFU_G2_LV_E]; // [RL18]
    end
  end

  // checks
  a_edge_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [RL4]
    regs_q[IX_EDG][7:4] == 4'h0)
    else $error("edge register upper bits not zero");

  a_pin_a_rise: assert property (@(posedge aclk) disable iff (!aresetn) // [RL2]
    (regs_q[IX_EDG][1:0] == 2'h1 && ext_irq_pin_a && !pin_prev_q[0])
      |=> regs_q[IX_P0][`MIFU_P0_PIN_A_F])
    else $error("pin a rising edge did not set its flag");

  a_pin_b_fall: assert property (@(posedge aclk) disable iff (!aresetn) // [RL1]
    (regs_q[IX_EDG][3:2] == 2'h2 && !ext_irq_pin_b && pin_prev_q[1])
      |=> regs_q[IX_P2][`MIFU_P2_PIN_B_F])
    else $error("pin b falling edge did not set its flag");

  a_pin_b_off: assert property (@(posedge aclk) disable iff (!aresetn) // [RL3]
    (regs_q[IX_EDG][3:2] == 2'h0 && !regs_q[IX_P2][`MIFU_P2_PIN_B_F] && !do_wr)
      |=> !regs_q[IX_P2][`MIFU_P2_PIN_B_F])
    else $error("disabled pin b raised a request");

  a_cmp_flag_set: assert property (@(posedge aclk) disable iff (!aresetn) // [RL14]
    src_events.comparator |=> regs_q[IX_P0][`MIFU_P0_CMP_F])
    else $error("comparator event lost");

  a_adc_flag_set: assert property (@(posedge aclk) disable iff (!aresetn) // [RL15]
    src_events.converter |=> regs_q[IX_P1][`MIFU_P1_ADC_F])
    else $error("converter event lost");

  a_tb0_flag_set: assert property (@(posedge aclk) disable iff (!aresetn) // [RL11]
    src_events.timebase0 |=> regs_q[IX_P1][`MIFU_P1_TB0_F])
    else $error("time base 0 event lost");

  a_async_flag_set: assert property (@(posedge aclk) disable iff (!aresetn) // [RL16]
    src_events.async_serial |=> regs_q[IX_P2][`MIFU_P2_ASYNC_F])
    else $error("async serial event lost");

  a_group_summary: assert property (@(posedge aclk) disable iff (!aresetn) // [RL20]
    (|(regs_q[IX_G0][7:4] & regs_q[IX_G0][3:0])) |=> regs_q[IX_P0][`MIFU_P0_GRP0_F])
    else $error("group 0 flag not raised by enabled secondary");

  a_grp0_reserved: assert property (@(posedge aclk) disable iff (!aresetn) // [RL17]
    regs_q[IX_G0][3:2] == 2'h0 && regs_q[IX_G0][7:6] == 2'h0)
    else $error("group 0 reserved bits not zero");

  a_pri0_bit7: assert property (@(posedge aclk) disable iff (!aresetn) // [RL10]
    regs_q[IX_P0][7] == 1'b0)
    else $error("control 0 bit 7 not zero");

  a_irq_needs_global: assert property (@(posedge aclk) disable iff (!aresetn) // [RL19]
    irq_req_q |-> $past(regs_q[IX_P0][`MIFU_P0_GLOBAL_E]) && $past(pend))
    else $error("request raised without global enable");

  a_irq_raised: assert property (@(posedge aclk) disable iff (!aresetn) // [RL7]
    (regs_q[IX_P1][`MIFU_P1_ADC_F] && regs_q[IX_P1][2] && regs_q[IX_P0][0]) |=> irq_req_q)
    else $error("enabled converter request not passed to core");

  a_lv_delayed: assert property (@(posedge aclk) disable iff (!aresetn) // [RL18]
    (!low_voltage_output_bit ##1 low_voltage_output_bit) |-> lv_cnt_q == 8'h00 && !lv_set)
    else $error("low-voltage flag set without the delay");

  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (bvalid_q && !bready) |=> bvalid_q && $stable(bresp_q))
    else $error("write response dropped before taken");

  c_pin_a_both: cover property (@(posedge aclk) disable iff (!aresetn)
    regs_q[IX_EDG][1:0] == 2'h3 && pin_hit[0]);
  c_irq_rise: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq_req_q));
  c_lv_set: cover property (@(posedge aclk) disable iff (!aresetn) lv_set);
  c_write_done: cover property (@(posedge aclk) disable iff (!aresetn) bvalid_q && bready);

endmodule : mifu_top

// ### tb/mifu_src_model.sv
/*
  model of the peripheral sources that face the interrupt unit: event pulses
  and the low-voltage detector output.
  assumes the bench calls its tasks just after a rising edge of aclk.
*/
module mifu_src_model (
  input  wire logic           aclk,
  output mifu_pkg::mifu_src_t src_events,
  output logic                lv_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import mifu_pkg::*;

  initial begin
    src_events = '0;
    lv_out     = 1'b0;
  end

  // each source signals its event as a single-cycle pulse
  task automatic pulse(input mifu_src_t p);
    src_events <= p;
    @(posedge aclk);
    src_events <= '0;
    @(posedge aclk);
  endtask : pulse

  // detector output held high for n cycles, then dropped
  task automatic lv_high(input int n);
    lv_out <= 1'b1;
    repeat (n) @(posedge aclk);
    lv_out <= 1'b0;
    @(posedge aclk);
  endtask : lv_high
endmodule : mifu_src_model

// ### tb/tb.sv
/*
  self-checking bench of the interrupt flag and enable unit over AXI4-Lite.
  assumes the register offsets of mifu_map.svh and the source model beside it.
*/
`include "mifu_map.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mifu_pkg::*;

  localparam logic [7:0] o_edge = `MIFU_OFF_EDGE_SEL;
  localparam logic [7:0] o_p0   = `MIFU_OFF_PRI_0;
  localparam logic [7:0] o_p1   = `MIFU_OFF_PRI_1;
  localparam logic [7:0] o_p2   = `MIFU_OFF_PRI_2;
  localparam logic [7:0] o_g0   = `MIFU_OFF_GRP_0;
  localparam logic [7:0] o_g1   = `MIFU_OFF_GRP_1;
  localparam logic [7:0] o_g2   = `MIFU_OFF_GRP_2;

  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0, strb = 4'h1;
  logic        awready, wready, bvalid, arready, rvalid, irq_req, lv_wake, lv_bit;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        pin_a = 1'b0, pin_b = 1'b0;
  mifu_src_t   src_events;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          error_cnt = 0, n_compared = 0, cyc = 0;
  logic [7:0]  w0, w1;
  logic [5:0]  r;
  logic [1:0]  f0, e0;
  logic [3:0]  f1, e1;
  logic [1:0]  m;

  always #20 aclk = ~aclk;

  mifu_top u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b), .src_events(src_events),
    .low_voltage_output_bit(lv_bit), .irq_req(irq_req), .lv_wake(lv_wake));

  mifu_src_model u_src (.aclk(aclk), .src_events(src_events), .lv_out(lv_bit));

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic wrr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d  = 1'b0;
    bq.push_back(er);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= {24'h0, d};
    wstrb   <= strb;
    bready  <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge aclk);
      if (!aw_d && awready) begin
        aw_d = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_d && wready) begin
        w_d = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wrr

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wrr(a, d, `MIFU_RESP_OKAY);
  endtask : wr

  task automatic rdr(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rdr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rdr(a, {`MIFU_RESP_OKAY, 24'h0, e});
  endtask : rd

  // irq_req and lv_wake trail the register state by one edge
  task automatic chk(input logic got_sel, input logic e);
    repeat (2) @(posedge aclk);
    cmp({33'h0, got_sel ? lv_wake : irq_req}, {33'h0, e});
  endtask : chk

  // result monitor: every handshake takes the oldest note
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      cmp({rresp, rdata}, (rq.size() > 0) ? rq.pop_front() : ~{rresp, rdata});
    end
    if (bvalid && bready) begin
      cmp({32'h0, bresp}, (bq.size() > 0) ? {32'h0, bq.pop_front()} : 34'h3);
    end
  end

  // the cycle budget covers every scenario with a wide margin
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    void'($urandom(32'h712f));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 7; i++) rd(8'(4 * i), 8'h00);
    wrr(8'h1c, 8'h5a, `MIFU_RESP_SLVERR);
    rdr(8'h1c, {`MIFU_RESP_SLVERR, 32'h0});
    strb = 4'h0;
    wr(o_p2, 8'hff);
    strb = 4'h1;
    rd(o_p2, 8'h00);
    // every edge mode on both pins, rising then falling
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      wr(o_edge, {4'ha, m, m});
      rd(o_edge, {4'h0, m, m});
      wr(o_p0, 8'h00);
      wr(o_p2, 8'h00);
      pin_a <= 1'b1;
      pin_b <= 1'b1;
      repeat (3) @(posedge aclk);
      rd(o_p0, {3'h0, m[0], 4'h0});
      rd(o_p2, {2'h0, m[0], 5'h0});
      wr(o_p0, 8'h00);
      wr(o_p2, 8'h00);
      pin_a <= 1'b0;
      pin_b <= 1'b0;
      repeat (3) @(posedge aclk);
      rd(o_p0, {3'h0, m[1], 4'h0});
      rd(o_p2, {2'h0, m[1], 5'h0});
    end
    wr(o_p0, 8'h00);
    wr(o_p2, 8'h00);
    u_src.pulse(13'h1f80);
    rd(o_p0, 8'h20);
    rd(o_p1, 8'hc0);
    rd(o_p2, 8'hd0);
    chk(1'b0, 1'b0);
    wr(o_p1, 8'hc4);
    chk(1'b0, 1'b0);
    wr(o_p0, 8'h21);
    chk(1'b0, 1'b1);
    wr(o_p1, 8'h80);
    chk(1'b0, 1'b0);
    wr(o_p0, 8'h25);
    chk(1'b0, 1'b1);
    wr(o_p1, 8'h00);
    wr(o_p2, 8'h00);
    // random secondary flags, enables and events
    for (int i = 0; i < 8; i++) begin
      w0 = 8'($urandom);
      w1 = 8'($urandom);
      r  = 6'($urandom);
      wr(o_g0, w0);
      wr(o_g1, w1);
      u_src.pulse({7'h0, r});
      f0 = w0[5:4] | r[5:4];
      f1 = w1[7:4] | r[3:0];
      e0 = w0[1:0];
      e1 = w1[3:0];
      wr(o_p1, 8'h01);
      wr(o_p0, 8'h09);
      rd(o_g0, {2'h0, f0, 2'h0, e0});
      rd(o_g1, {f1, e1});
      rd(o_p0, {1'b0, |(f0 & e0), 6'h09});
      rd(o_p1, {3'h0, |(f1 & e1), 4'h1});
      chk(1'b0, |(f0 & e0) | |(f1 & e1));
    end
    wr(o_g0, 8'h00);
    wr(o_g1, 8'h00);
    wr(o_g2, 8'h01);
    wr(o_p1, 8'h02);
    wr(o_p0, 8'h01);
    u_src.pulse(13'h0040);
    u_src.lv_high(20);
    rd(o_g2, 8'h21);
    chk(1'b0, 1'b0);
    u_src.lv_high(30);
    rd(o_g2, 8'h31);
    chk(1'b1, 1'b1);
    chk(1'b0, 1'b1);
    // group flag stays pending but its group enable is now off
    wr(o_p1, 8'h20);
    chk(1'b0, 1'b0);
    rd(o_p1, 8'h20);
    final_report();
  end
endmodule : tb
